// *** src/eac_top.sv ***
`timescale 1ns/1ps
module eac_top #(
  parameter int unsigned AL_WORDS = 2,
  parameter logic [6:0]  AL_BASE  = 7'h00,
  parameter logic [6:0]  DEV_ADDR = 7'h50,
  parameter int unsigned QTR_NORM = eac_pkg::QTR_CYC,
  parameter int unsigned QTR_TEST = eac_pkg::TEST_QTR_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o,
  output logic                      scl_o,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_n_o,
  output logic [AL_WORDS*16-1:0]    cfg_words_o,
  output logic                      irq_o
);
  import eac_pkg::*;

  localparam int unsigned IW = $clog2(AL_WORDS);

  if (AL_WORDS < 2 || AL_WORDS > 8) $error("AL_WORDS out of range");

  typedef struct packed {
    eac_ctrl_t                   ctrl;
    logic [EV_W-1:0]             sts;
    logic [EV_W-1:0]             mask;
    logic                        irq;
    logic [ADDR_W-1:0]           ph_addr;
    logic                        ph_wr;
    logic                        rd_pend;
    logic [31:0]                 hrdata;
    eac_fsm_t                    fsm;
    logic [1:0]                  phase;
    logic [2:0]                  bit_cnt;
    logic [2:0]                  byte_idx;
    logic                        rx_last;
    logic                        nak;
    logic                        err;
    logic                        is_rd;
    logic [6:0]                  cur_addr;
    logic [7:0]                  tx_sh;
    logic [15:0]                 rx_sh;
    logic                        al_run;
    logic                        al_done;
    logic                        al_ok;
    logic [IW-1:0]               al_idx;
    logic [AL_WORDS-1:0][15:0]   al_data;
    logic                        scl;
    logic                        sda_low;
    logic [1:0]                  sync;
  } eac_st_t;

  eac_st_t st_r;
  eac_st_t st_nxt;
  logic    tick;
  logic    acc;
  logic    al_pending;
  logic    launch_man;
  logic    finish;
  logic    sda_s;

  //////////////////////////////////////////////////////////////////////////////
  eac_clkdiv #(
    .QTR_NORM (QTR_NORM),
    .QTR_TEST (QTR_TEST)
  ) u_div (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .rate_i    (st_r.ctrl.clk_rate),
    .run_i     (st_r.fsm != ST_IDLE),
    .tick_o    (tick)
  );

  function automatic logic [7:0] tx_byte(input eac_st_t s);
    logic [7:0] b;
    b = {DEV_ADDR, DIR_WR};
    if (s.byte_idx == 3'h1)
      b = {s.cur_addr, 1'b0};
    else if (s.byte_idx == 3'h2)
      b = s.is_rd ? {DEV_ADDR, DIR_RD} : s.ctrl.word_data[15:8];
    else if (s.byte_idx == 3'h3)
      b = s.ctrl.word_data[7:0];
    return b;
  endfunction : tx_byte

  assign sda_s      = st_r.sync[1];
  assign acc        = hsel_i && htrans_i[1] && hready_i;
  assign al_pending = !st_r.al_done && !st_r.ctrl.al_dis && !st_r.al_run;
  assign launch_man = (st_r.fsm == ST_IDLE) && !al_pending && !st_r.al_run && st_r.ctrl.start;
  assign finish     = tick && (st_r.fsm == ST_STOP) && (st_r.phase == 2'h3);

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.sync = {st_r.sync[0], sda_i};

    // bus slave: reads take one wait state so a write just before is seen
    if (st_r.ph_wr)
    begin
      if (st_r.ph_addr == OFS_CTRL)
      begin
        if (st_r.fsm == ST_IDLE && !st_r.ctrl.start && !st_r.al_run)
        begin
          st_nxt.ctrl.start     = hwdata_i[0];
          st_nxt.ctrl.cmd       = hwdata_i[1];
          st_nxt.ctrl.al_dis    = hwdata_i[5];
          st_nxt.ctrl.clk_rate  = hwdata_i[7:6];
          st_nxt.ctrl.word_addr = hwdata_i[15:9];
          st_nxt.ctrl.word_data = hwdata_i[31:16];
        end
      end
      else if (st_r.ph_addr == OFS_STS)
        st_nxt.sts = st_r.sts & ~hwdata_i[EV_W-1:0];
      else if (st_r.ph_addr == OFS_MASK)
        st_nxt.mask = hwdata_i[EV_W-1:0];
    end
    st_nxt.ph_wr = acc && hwrite_i;
    if (acc)
      st_nxt.ph_addr = haddr_i[ADDR_W-1:0];
    st_nxt.rd_pend = acc && !hwrite_i;
    if (st_r.rd_pend)
    begin
      if (st_r.ph_addr == OFS_CTRL)
      begin
        st_nxt.hrdata          = st_r.ctrl;
        st_nxt.ctrl.al_succ    = 1'b0;
      end
      else if (st_r.ph_addr == OFS_STS)
        st_nxt.hrdata = {{(32-EV_W){1'b0}}, st_r.sts};
      else if (st_r.ph_addr == OFS_MASK)
        st_nxt.hrdata = {{(32-EV_W){1'b0}}, st_r.mask};
      else
        st_nxt.hrdata = 32'h0000_0000;
    end

    // launch: autoload has priority, a pending start waits for it
    if (st_r.fsm == ST_IDLE)
    begin
      if (al_pending)
      begin
        st_nxt.al_run   = 1'b1;
        st_nxt.al_ok    = 1'b1;
        st_nxt.al_idx   = '0;
        st_nxt.cur_addr = AL_BASE;
        st_nxt.is_rd    = 1'b1;
      end
      else if (launch_man)
      begin
        st_nxt.cur_addr = st_r.ctrl.word_addr;
        st_nxt.is_rd    = (st_r.ctrl.cmd == CMD_READ);
      end
      if (al_pending || launch_man)
      begin
        st_nxt.fsm      = ST_START;
        st_nxt.phase    = 2'h0;
        st_nxt.byte_idx = 3'h0;
        st_nxt.err      = 1'b0;
      end
    end
    else if (tick)
    begin
      st_nxt.phase = st_r.phase + 2'h1;
      if (st_r.phase == 2'h2)
      begin
        if (st_r.fsm == ST_RACK)
          st_nxt.nak = sda_s;
        if (st_r.fsm == ST_RX)
          st_nxt.rx_sh = {st_r.rx_sh[14:0], sda_s};
      end
      if (st_r.phase == 2'h3)
      begin
        case (st_r.fsm)
          ST_START:
          begin
            st_nxt.fsm     = ST_TX;
            st_nxt.tx_sh   = tx_byte(st_r);
            st_nxt.bit_cnt = 3'h0;
          end
          ST_TX:
          begin
            st_nxt.tx_sh   = {st_r.tx_sh[6:0], 1'b0};
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7)
              st_nxt.fsm = ST_RACK;
          end
          ST_RACK:
          begin
            st_nxt.byte_idx = st_r.byte_idx + 3'h1;
            st_nxt.bit_cnt  = 3'h0;
            if (st_r.nak)
            begin
              st_nxt.err = 1'b1;
              st_nxt.fsm = ST_STOP;
            end
            else if (st_r.is_rd && st_r.byte_idx == 3'h1)
              st_nxt.fsm = ST_START;
            else if (st_r.is_rd && st_r.byte_idx == 3'h2)
            begin
              st_nxt.fsm     = ST_RX;
              st_nxt.rx_last = 1'b0;
            end
            else if (!st_r.is_rd && st_r.byte_idx == 3'h3)
              st_nxt.fsm = ST_STOP;
            else
            begin
              st_nxt.fsm   = ST_TX;
              st_nxt.byte_idx = st_r.byte_idx + 3'h1;
              st_nxt.tx_sh = tx_byte(st_nxt);
            end
          end
          ST_RX:
          begin
            st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
            if (st_r.bit_cnt == 3'h7)
              st_nxt.fsm = ST_TACK;
          end
          ST_TACK:
          begin
            st_nxt.bit_cnt = 3'h0;
            st_nxt.rx_last = 1'b1;
            st_nxt.fsm     = st_r.rx_last ? ST_STOP : ST_RX;
          end
          ST_STOP:
          begin
            st_nxt.fsm = ST_IDLE;
            if (st_r.al_run)
            begin
              if (!st_r.err)
                st_nxt.al_data[st_r.al_idx] = st_r.rx_sh;
              if (st_r.err || st_r.al_idx == IW'(AL_WORDS - 1))
              begin
                st_nxt.al_run       = 1'b0;
                st_nxt.al_done      = 1'b1;
                st_nxt.ctrl.al_succ = st_r.al_ok && !st_r.err;
                st_nxt.ctrl.al_stat = st_r.al_ok && !st_r.err;
                st_nxt.sts[EV_AL]   = 1'b1;
              end
              else
              begin
                // next word reuses the launch path without a bus round trip
                st_nxt.al_idx   = st_r.al_idx + IW'(1);
                st_nxt.cur_addr = st_r.cur_addr + 7'h01;
                st_nxt.fsm      = ST_START;
                st_nxt.byte_idx = 3'h0;
              end
              st_nxt.al_ok = st_r.al_ok && !st_r.err;
            end
            else
            begin
              st_nxt.ctrl.start = 1'b0;
              st_nxt.ctrl.err   = st_r.err;
              if (st_r.is_rd && !st_r.err)
                st_nxt.ctrl.word_data = st_r.rx_sh;
              st_nxt.sts[EV_DONE] = 1'b1;
              if (st_r.err)
                st_nxt.sts[EV_ERR] = 1'b1;
            end
          end
          default:
            st_nxt.fsm = ST_IDLE;
        endcase
      end
    end

    // pin drive from the next state, so both pins come from flops
    case (st_nxt.fsm)
      ST_START:
      begin
        st_nxt.scl     = (st_nxt.phase == 2'h1) || (st_nxt.phase == 2'h2);
        st_nxt.sda_low = st_nxt.phase[1];
      end
      ST_TX:
      begin
        st_nxt.scl     = st_nxt.phase[0] ^ st_nxt.phase[1];
        st_nxt.sda_low = !st_nxt.tx_sh[7];
      end
      ST_TACK:
      begin
        st_nxt.scl     = st_nxt.phase[0] ^ st_nxt.phase[1];
        st_nxt.sda_low = !st_nxt.rx_last;
      end
      ST_RACK, ST_RX:
      begin
        st_nxt.scl     = st_nxt.phase[0] ^ st_nxt.phase[1];
        st_nxt.sda_low = 1'b0;
      end
      ST_STOP:
      begin
        st_nxt.scl     = (st_nxt.phase != 2'h0);
        st_nxt.sda_low = !st_nxt.phase[1];
      end
      default:
      begin
        st_nxt.scl     = 1'b1;
        st_nxt.sda_low = 1'b0;
      end
    endcase

    st_nxt.irq = |(st_nxt.sts & st_nxt.mask);
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      st_r      <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.scl  <= 1'b1;
      st_r.fsm  <= ST_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  //////////////////////////////////////////////////////////////////////////////
  assign hreadyout_o = !st_r.rd_pend;
  assign hresp_o     = HRESP_OKAY;
  assign hrdata_o    = st_r.hrdata;
  assign scl_o       = st_r.scl;
  assign sda_o       = 1'b0;
  assign sda_oe_n_o  = !st_r.sda_low;
  assign cfg_words_o = st_r.al_data;
  assign irq_o       = st_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_start_launch: assert property (launch_man |=> st_r.fsm == ST_START)
    else $error("start did not launch a cycle");
  a_cmd_select: assert property (launch_man |=> st_r.is_rd == !$past(st_r.ctrl.cmd))
    else $error("command bit not honoured");
  a_err_flag: assert property (finish && !st_r.al_run |=> st_r.ctrl.err == $past(st_r.err))
    else $error("error flag wrong after cycle");
  a_succ_clear: assert property (st_r.rd_pend && st_r.ph_addr == OFS_CTRL && !finish
    |=> !st_r.ctrl.al_succ)
    else $error("success flag not cleared by read");
  a_stat_ok: assert property (st_r.ctrl.al_stat |-> st_r.al_done && st_r.al_ok)
    else $error("autoload status without good autoload");
  a_al_gate: assert property (st_r.ctrl.al_dis && !st_r.al_run |=> !st_r.al_run)
    else $error("autoload ran while disabled");
  a_rst_vals: assert property ($rose(reset_n_i) |-> st_r.ctrl.clk_rate == RATE_DIV
    && st_r.ctrl.al_dis && !st_r.ctrl.start)
    else $error("control reset values wrong");
  a_addr_use: assert property (launch_man |=> st_r.cur_addr == $past(st_r.ctrl.word_addr))
    else $error("word address not used");
  a_read_load: assert property (finish && !st_r.al_run && st_r.is_rd && !st_r.err
    |=> st_r.ctrl.word_data == $past(st_r.rx_sh))
    else $error("read data not loaded");
  a_start_clear: assert property (finish && !st_r.al_run |=> !st_r.ctrl.start
    ##1 st_r.fsm == ST_IDLE || st_r.fsm == ST_START)
    else $error("start bit not cleared at end");
  a_read_wait: assert property (acc && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");

endmodule : eac_top

// *** src/eac_pkg.sv ***
package eac_pkg;

  // serial clock timing
  localparam int unsigned CORE_MHZ      = 125;
  localparam int unsigned DIV_FACTOR    = 1024;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned SCL_PERIOD_NS = DIV_FACTOR * 1000 / CORE_MHZ;
  localparam int unsigned QTR_CYC       = SCL_PERIOD_NS * CLK_MHZ / 1000 / 4;
  localparam int unsigned TEST_QTR_CYC  = 4;

  // register map
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  OFS_STS  = 8'h00;
  localparam logic [7:0]  OFS_MASK = 8'h04;
  localparam logic [7:0]  OFS_CTRL = 8'hBC;

  // clock rate encodings
  localparam logic [1:0] RATE_RSV0 = 2'h0;
  localparam logic [1:0] RATE_DIV  = 2'h1;
  localparam logic [1:0] RATE_RSV2 = 2'h2;
  localparam logic [1:0] RATE_TEST = 2'h3;

  localparam logic CMD_READ  = 1'b0;
  localparam logic CMD_WRITE = 1'b1;
  localparam logic DIR_WR    = 1'b0;
  localparam logic DIR_RD    = 1'b1;

  // event bits of status and mask
  localparam int unsigned EV_W    = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_ERR  = 1;
  localparam int unsigned EV_AL   = 2;

  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic [15:0] word_data;
    logic [6:0]  word_addr;
    logic        rsvd;
    logic [1:0]  clk_rate;
    logic        al_dis;
    logic        al_stat;
    logic        al_succ;
    logic        err;
    logic        cmd;
    logic        start;
  } eac_ctrl_t;

  localparam eac_ctrl_t CTRL_RST = '{
    word_data: 16'h0000, word_addr: 7'h00, rsvd: 1'b0, clk_rate: RATE_DIV,
    al_dis: 1'b1, al_stat: 1'b0, al_succ: 1'b0, err: 1'b0, cmd: CMD_READ, start: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_TX, ST_RACK, ST_RX, ST_TACK, ST_STOP
  } eac_fsm_t;

endpackage : eac_pkg

// *** src/eac_clkdiv.sv ***
`timescale 1ns/1ps
module eac_clkdiv #(
  parameter int unsigned QTR_NORM = eac_pkg::QTR_CYC,
  parameter int unsigned QTR_TEST = eac_pkg::TEST_QTR_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [1:0] rate_i,
  input  wire logic       run_i,
  output logic            tick_o
);
  import eac_pkg::*;

  localparam int unsigned CW = $clog2(QTR_NORM);

  if (QTR_TEST < 2 || QTR_TEST > QTR_NORM) $error("bad quarter counts");

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } eac_div_t;

  eac_div_t st_r;
  eac_div_t st_nxt;
  logic [CW-1:0] last;

  // reserved encodings fall back to the normal divider
  assign last = (rate_i == RATE_TEST) ? CW'(QTR_TEST - 1) : CW'(QTR_NORM - 1);

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!run_i)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt >= last)
    begin
      st_nxt.cnt  = '0;
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign tick_o = st_r.tick;

endmodule : eac_clkdiv

// *** testbench/eac_eeprom_model.sv ***
`timescale 1ns/1ps
module eac_eeprom_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic nak_i,
  output logic      pull_low_o
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic       act;
  logic       rd;
  logic       ackph;
  int         nbit;
  int         nbyte;

  initial
  begin
    pull_low_o = 1'b0;
    act        = 1'b0;
    ptr        = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // start or repeated start: data falls while clock high
  always @(negedge sda_i)
    if (scl_i === 1'b1)
    begin
      act   = 1'b1;
      rd    = 1'b0;
      ackph = 1'b0;
      nbit  = 0;
      nbyte = 0;
    end

  // stop ends any transfer
  always @(posedge sda_i)
    if (scl_i === 1'b1)
      act = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge scl_i)
    if (act)
    begin
      if (ackph && rd && sda_i)
        act = 1'b0;
      else if (!ackph)
      begin
        if (!(rd && nbyte > 0))
          sh = {sh[6:0], sda_i};
        nbit++;
      end
    end

  // drive only while clock low, so a start or stop is never faked
  always @(negedge scl_i)
    if (act)
    begin
      pull_low_o = 1'b0;
      if (ackph)
      begin
        ackph = 1'b0;
        nbit  = 0;
        if (rd)
        begin
          sh = mem[ptr];
          ptr++;
          pull_low_o = ~sh[7];
        end
      end
      else if (nbit == 8)
      begin
        ackph = 1'b1;
        if (!rd)
        begin
          if (nbyte == 0)
            rd = sh[0];
          else if (nbyte == 1)
            ptr = sh;
          else
          begin
            mem[ptr] = sh;
            ptr++;
          end
          // refusal leaves the line to the pull-up
          pull_low_o = !nak_i && (nbyte > 0 || sh[7:1] == DEV);
          act = pull_low_o;
        end
        nbyte++;
      end
      else if (rd && nbyte > 0)
        pull_low_o = ~sh[7 - nbit];
    end
endmodule : eac_eeprom_model

// *** testbench/eac_top_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      fails++; \
      $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); \
    end \
  end
module eac_top_tb_top;
  import eac_pkg::*;
  logic        clk_i;
  logic        reset_n_i;
  logic        hsel;
  logic        hwrite;
  logic        pull_low;
  logic        nak;
  logic        hready;
  logic        hresp;
  logic        scl;
  logic        sda_o;
  logic        sda_oe_n;
  logic        irq;
  logic        sda;
  logic        scl_q;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] cfg;
  int          fails;
  int          n_compared;
  int          cnt;
  int          per;

  // released data line floats to the pull-up
  assign sda = sda_oe_n ? ~pull_low : 1'b0;

  // word count, base and device code stay at their defaults
  eac_top #(.QTR_NORM(8), .QTR_TEST(4)) i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
    .scl_o(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
    .cfg_words_o(cfg), .irq_o(irq));

  eac_eeprom_model #(.DEV(7'h50)) i_eep (
    .scl_i(scl), .sda_i(sda), .nak_i(nak), .pull_low_o(pull_low));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // clock cycles between serial clock rises
  always @(posedge clk_i)
  begin
    scl_q <= scl;
    cnt   <= cnt + 1;
    if (scl === 1'b1 && scl_q === 1'b0)
    begin
      per <= cnt;
      cnt <= 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [15:0] d, input logic [6:0] a,
                                      input logic [1:0] r, input logic [5:0] lo);
    return {d, a, 1'b0, r, lo};
  endfunction : ctl

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    begin
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 50);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      if (n >= 100)
        fails++;
    end
  endtask : ahb

  // bounded wait: each read takes three cycles
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    begin
      n = 0;
      do begin ahb(1'b0, a, 32'h0); n++; end while (rd[b] !== v && n < 4000);
      `CHK(rd[b], v)
    end
  endtask : poll

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (90000) @(posedge clk_i);
    fails++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata, nak, reset_n_i} = '0;
    {fails, n_compared, cnt, per} = '0;
    for (int i = 0; i < 256; i++)
      i_eep.mem[i] = 8'(i) ^ 8'h5A;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0060)
    `CHK(hresp, HRESP_OKAY)
    `CHK(sda_o, 1'b0)
    ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h10, 32'h0);
    `CHK(rd, 32'h0000_0000)
    ahb(1'b1, OFS_MASK, 32'h7);
    // write cycle at the normal rate
    ahb(1'b1, OFS_CTRL, ctl(16'h1234, 7'h05, 2'h1, 6'h23));
    poll(OFS_CTRL, 0, 1'b0);
    `CHK(rd, ctl(16'h1234, 7'h05, 2'h1, 6'h22))
    `CHK({i_eep.mem[10], i_eep.mem[11]}, 16'h1234)
    `CHK(per, 32)
    `CHK(irq, 1'b1)
    ahb(1'b1, OFS_STS, 32'h7);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    // read cycle; a control write while busy must be dropped
    ahb(1'b1, OFS_CTRL, ctl(16'h0000, 7'h07, 2'h1, 6'h21));
    ahb(1'b1, OFS_CTRL, ctl(16'hFFFF, 7'h11, 2'h1, 6'h23));
    poll(OFS_CTRL, 0, 1'b0);
    `CHK(rd, ctl({i_eep.mem[14], i_eep.mem[15]}, 7'h07, 2'h1, 6'h20))
    // refused acknowledge
    nak <= 1'b1;
    ahb(1'b1, OFS_CTRL, ctl(16'h0000, 7'h03, 2'h1, 6'h21));
    poll(OFS_CTRL, 0, 1'b0);
    `CHK(rd[2], 1'b1)
    nak <= 1'b0;
    ahb(1'b0, OFS_STS, 32'h0);
    `CHK(rd[1], 1'b1)
    ahb(1'b1, OFS_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    ahb(1'b1, OFS_MASK, 32'h7);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b1)
    ahb(1'b1, OFS_STS, 32'h7);
    repeat (3) @(posedge clk_i);
    `CHK(irq, 1'b0)
    // test rate, top word address
    ahb(1'b1, OFS_CTRL, ctl(16'hBEEF, 7'h7F, 2'h3, 6'h23));
    poll(OFS_CTRL, 0, 1'b0);
    `CHK(rd, ctl(16'hBEEF, 7'h7F, 2'h3, 6'h22))
    `CHK({i_eep.mem[254], i_eep.mem[255]}, 16'hBEEF)
    `CHK(per, 16)
    // reserved rate code runs at the normal divider
    ahb(1'b1, OFS_CTRL, ctl(16'hA55A, 7'h20, 2'h0, 6'h23));
    poll(OFS_CTRL, 0, 1'b0);
    `CHK(rd, ctl(16'hA55A, 7'h20, 2'h0, 6'h22))
    `CHK({i_eep.mem[64], i_eep.mem[65]}, 16'hA55A)
    `CHK(per, 32)
    // autoload once enabled
    ahb(1'b1, OFS_CTRL, ctl(16'h0000, 7'h00, 2'h1, 6'h00));
    poll(OFS_STS, 2, 1'b1);
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[5:0], 6'h18)
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[5:0], 6'h10)
    `CHK(cfg, {i_eep.mem[2], i_eep.mem[3], i_eep.mem[0], i_eep.mem[1]})
    // second reset: autoload outcome and loaded words go back to defaults
    reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'b1;
    ahb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd, 32'h0000_0060)
    `CHK(cfg, 32'h0000_0000)
    summarize();
  end
endmodule : eac_top_tb_top
